//--- cllc_csrs.sv
/*
  Core low-level control register bank: feature disable, clock gate override,
  interrupt enable and interrupt pending, reached through the core CSR port.
  Assumes the CSR port is driven from logic on i_ref_clk and that the three
  interrupt request lines may come from other domains or pins.
*/
`include "cllc_defs.svh"

module cllc_csrs
  import cllc_pkg::*;
#(
  parameter int BUS_AXI = 1
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_csr_rd_en,
  input  wire logic        i_csr_wr_en,
  input  wire logic [11:0] i_csr_addr,
  input  wire logic [31:0] i_csr_wdata,
  input  wire logic        i_ce_irq,
  input  wire logic        i_ext_irq,
  input  wire logic        i_tmr_irq,
  output logic      [31:0] o_csr_rdata,
  output logic             o_csr_hit,
  output logic      [2:0]  o_dma_qos,
  output logic             o_dual_issue_off,
  output logic             o_ecc_chk_off,
  output logic             o_alu2_off,
  output logic             o_se_store_blocking,
  output logic             o_se_load_blocking,
  output logic             o_nonblock_off,
  output logic             o_fast_div_off,
  output logic             o_bpred_off,
  output logic             o_coalesce_off,
  output logic             o_pipelining_off,
  output logic      [8:0]  o_cg_override,
  output logic             o_ce_irq_req,
  output logic             o_ext_irq_req,
  output logic             o_tmr_irq_req
);

  // ----------------------------------------
  // build checks
  // ----------------------------------------
  generate
    if (BUS_AXI != 0 && BUS_AXI != 1) begin : g_bad_bus
      $error("BUS_AXI must be 0 or 1");
    end
  endgenerate

  localparam logic SEPD_RST = (BUS_AXI == 1) ? 1'b1 : 1'b0;

  cllc_state_t st_r;
  cllc_state_t st_nxt;
  logic [31:0] fdc_word;
  logic [31:0] cgc_word;
  logic [31:0] ie_word;
  logic [31:0] ip_word;

  // ----------------------------------------
  // read views, only legal bits populated
  // ----------------------------------------
  always_comb begin
    fdc_word = 32'h0000_0000;
    fdc_word[`CLLC_FDC_QOS_HI:`CLLC_FDC_QOS_LO] = st_r.dma_qos;
    fdc_word[`CLLC_FDC_DUAL]  = st_r.dual_issue_off;
    fdc_word[`CLLC_FDC_ECC]   = st_r.ecc_chk_off;
    fdc_word[`CLLC_FDC_ALU2]  = st_r.alu2_off;
    fdc_word[`CLLC_FDC_SEPD]  = st_r.se_posted_off;
    fdc_word[`CLLC_FDC_NBLK]  = st_r.nonblock_off;
    fdc_word[`CLLC_FDC_FDIV]  = st_r.fast_div_off;
    fdc_word[`CLLC_FDC_BPRED] = st_r.bpred_off;
    fdc_word[`CLLC_FDC_COAL]  = st_r.coalesce_off;
    fdc_word[`CLLC_FDC_PIPE]  = st_r.pipelining_off;
    cgc_word = 32'h0000_0000;
    cgc_word[`CLLC_CGC_HI:0] = st_r.cg_override;
    ie_word = 32'h0000_0000;
    ie_word[`CLLC_IRQ_CE]  = st_r.ce_ie;
    ie_word[`CLLC_IRQ_EXT] = st_r.ext_ie;
    ie_word[`CLLC_IRQ_TMR] = st_r.tmr_ie;
    ie_word[`CLLC_IRQ_SW]  = st_r.sw_ie;
    ip_word = 32'h0000_0000;
    ip_word[`CLLC_IRQ_CE]  = st_r.irq_sync[2];
    ip_word[`CLLC_IRQ_EXT] = st_r.irq_sync[1];
    ip_word[`CLLC_IRQ_TMR] = st_r.irq_sync[0];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;

    // request levels pass two flops; pending lags the pins by two cycles
    st_nxt.irq_meta = {i_ce_irq, i_ext_irq, i_tmr_irq};
    st_nxt.irq_sync = st_r.irq_meta;

    // writes keep only the legal bits, the rest is dropped
    if (i_csr_wr_en) begin
      case (i_csr_addr)
        `CLLC_ADDR_FDC: begin
          st_nxt.dma_qos        = i_csr_wdata[`CLLC_FDC_QOS_HI:`CLLC_FDC_QOS_LO];
          st_nxt.dual_issue_off = i_csr_wdata[`CLLC_FDC_DUAL];
          st_nxt.ecc_chk_off    = i_csr_wdata[`CLLC_FDC_ECC];
          st_nxt.alu2_off       = i_csr_wdata[`CLLC_FDC_ALU2];
          st_nxt.se_posted_off  = i_csr_wdata[`CLLC_FDC_SEPD];
          st_nxt.nonblock_off   = i_csr_wdata[`CLLC_FDC_NBLK];
          st_nxt.fast_div_off   = i_csr_wdata[`CLLC_FDC_FDIV];
          st_nxt.bpred_off      = i_csr_wdata[`CLLC_FDC_BPRED];
          st_nxt.coalesce_off   = i_csr_wdata[`CLLC_FDC_COAL];
          st_nxt.pipelining_off = i_csr_wdata[`CLLC_FDC_PIPE];
        end
        `CLLC_ADDR_CGC: begin
          st_nxt.cg_override = i_csr_wdata[`CLLC_CGC_HI:0];
        end
        `CLLC_ADDR_IE: begin
          st_nxt.ce_ie  = i_csr_wdata[`CLLC_IRQ_CE];
          st_nxt.ext_ie = i_csr_wdata[`CLLC_IRQ_EXT];
          st_nxt.tmr_ie = i_csr_wdata[`CLLC_IRQ_TMR];
          st_nxt.sw_ie  = i_csr_wdata[`CLLC_IRQ_SW];
        end
        default: begin
          // pending register is read-only; other addresses ignored
          st_nxt.hit = st_r.hit;
        end
      endcase
    end

    // read data is registered: one cycle after the request
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.hit   = 1'b0;
    if (i_csr_rd_en) begin
      case (i_csr_addr)
        `CLLC_ADDR_FDC: begin
          st_nxt.rdata = fdc_word;
          st_nxt.hit   = 1'b1;
        end
        `CLLC_ADDR_CGC: begin
          st_nxt.rdata = cgc_word;
          st_nxt.hit   = 1'b1;
        end
        `CLLC_ADDR_IE: begin
          st_nxt.rdata = ie_word;
          st_nxt.hit   = 1'b1;
        end
        `CLLC_ADDR_IP: begin
          st_nxt.rdata = ip_word;
          st_nxt.hit   = 1'b1;
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r                <= '0;
      st_r.dma_qos        <= `CLLC_QOS_RST;
      st_r.se_posted_off  <= SEPD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // software fences around feature writes, so changes land mid-stream safely
  assign o_csr_rdata         = st_r.rdata;
  assign o_csr_hit           = st_r.hit;
  assign o_dma_qos           = st_r.dma_qos;
  assign o_dual_issue_off    = st_r.dual_issue_off;
  assign o_ecc_chk_off       = st_r.ecc_chk_off;
  assign o_alu2_off          = st_r.alu2_off;
  assign o_se_store_blocking = st_r.se_posted_off;
  assign o_se_load_blocking  = 1'b1;
  assign o_nonblock_off      = st_r.nonblock_off;
  assign o_fast_div_off      = st_r.fast_div_off;
  assign o_bpred_off         = st_r.bpred_off;
  assign o_coalesce_off      = st_r.coalesce_off;
  assign o_pipelining_off    = st_r.pipelining_off;
  assign o_cg_override       = st_r.cg_override;
  // there is no software interrupt request output, so sw_ie only reaches the enable readback
  assign o_ce_irq_req        = st_r.irq_sync[2] & st_r.ce_ie;
  assign o_ext_irq_req       = st_r.irq_sync[1] & st_r.ext_ie;
  assign o_tmr_irq_req       = st_r.irq_sync[0] & st_r.tmr_ie;

endmodule : cllc_csrs

//--- cllc_defs.svh
/*
  Holds the addresses, bit positions and reset values of the core low-level control register bank.
  Assumes it is included once per compilation unit, by its bare name.
*/
`ifndef CLLC_DEFS_SVH
`define CLLC_DEFS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define CLLC_ADDR_IE       12'h304
`define CLLC_ADDR_IP       12'h344
`define CLLC_ADDR_CGC      12'h7f8
`define CLLC_ADDR_FDC      12'h7f9

// ----------------------------------------
// feature disable fields
// ----------------------------------------
`define CLLC_FDC_QOS_HI    18
`define CLLC_FDC_QOS_LO    16
`define CLLC_FDC_DUAL      10
`define CLLC_FDC_ECC       8
`define CLLC_FDC_ALU2      7
`define CLLC_FDC_SEPD      6
`define CLLC_FDC_NBLK      5
`define CLLC_FDC_FDIV      4
`define CLLC_FDC_BPRED     3
`define CLLC_FDC_COAL      2
`define CLLC_FDC_PIPE      0
`define CLLC_QOS_RST       3'h7

// ----------------------------------------
// clock gate override fields
// ----------------------------------------
`define CLLC_CGC_HI        8
`define CLLC_CGC_RST       9'h000

// ----------------------------------------
// interrupt enable / pending fields
// ----------------------------------------
`define CLLC_IRQ_CE        30
`define CLLC_IRQ_EXT       11
`define CLLC_IRQ_TMR       7
`define CLLC_IRQ_SW        3

`endif

//--- cllc_pkg.sv
/*
  Holds the state type of the core low-level control register bank.
  Assumes cllc_defs.svh is in the include path.
*/
package cllc_pkg;

  // ----------------------------------------
  // whole register state of the bank
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]  dma_qos;
    logic        dual_issue_off;
    logic        ecc_chk_off;
    logic        alu2_off;
    logic        se_posted_off;
    logic        nonblock_off;
    logic        fast_div_off;
    logic        bpred_off;
    logic        coalesce_off;
    logic        pipelining_off;
    logic [8:0]  cg_override;
    logic        ce_ie;
    logic        ext_ie;
    logic        tmr_ie;
    logic        sw_ie;
    logic [2:0]  irq_meta;
    logic [2:0]  irq_sync;
    logic [31:0] rdata;
    logic        hit;
  } cllc_state_t;

endpackage : cllc_pkg

//--- cllc_csrs_checker.sv
/*
  Port-level checker of the core low-level control register bank.
  Assumes one clock domain and an asynchronous active-low reset.
*/
// ----------------------------------------
// checker
// ----------------------------------------
module cllc_csrs_checker
  import cllc_pkg::*;
#(
  parameter int BUS_AXI = 1
) (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic        i_csr_rd_en,
  input wire logic        i_csr_wr_en,
  input wire logic [11:0] i_csr_addr,
  input wire logic [31:0] i_csr_wdata,
  input wire logic        i_ext_irq,
  input wire logic [31:0] o_csr_rdata,
  input wire logic        o_csr_hit,
  input wire logic [2:0]  o_dma_qos,
  input wire logic        o_dual_issue_off,
  input wire logic        o_se_load_blocking,
  input wire logic [8:0]  o_cg_override,
  input wire logic        o_ext_irq_req
);
  logic mapped;
  assign mapped = i_csr_addr inside {12'h304, 12'h344, 12'h7f8, 12'h7f9};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_load_always_block: assert property (o_se_load_blocking)
    else $error("side-effect load not blocking");
  a_hit_mapped_read: assert property (o_csr_hit == $past(i_csr_rd_en && mapped))
    else $error("hit does not follow mapped read");
  a_rdata_idle_zero: assert property (!i_csr_rd_en |=> o_csr_rdata == 32'h0)
    else $error("read data not zero when idle");
  a_pend_read_mask: assert property ((i_csr_rd_en && i_csr_addr == 12'h344)
    |=> (o_csr_rdata & 32'hbffff77f) == 32'h0)
    else $error("pending read has stray bits");
  a_enable_read_mask: assert property ((i_csr_rd_en && i_csr_addr == 12'h304)
    |=> (o_csr_rdata & 32'hbffff777) == 32'h0)
    else $error("enable read has stray bits");
  a_cgc_write_lands: assert property ((i_csr_wr_en && i_csr_addr == 12'h7f8)
    |=> o_cg_override == $past(i_csr_wdata[8:0]))
    else $error("clock gate override write lost");
  a_fdc_write_lands: assert property ((i_csr_wr_en && i_csr_addr == 12'h7f9)
    |=> o_dma_qos == $past(i_csr_wdata[18:16]) && o_dual_issue_off == $past(i_csr_wdata[10]))
    else $error("feature disable write lost");
  a_ext_idle_quiet: assert property (!i_ext_irq [*4] |-> !o_ext_irq_req)
    else $error("external request without source");
endmodule : cllc_csrs_checker

bind cllc_csrs cllc_csrs_checker #(.BUS_AXI(BUS_AXI)) cllc_csrs_checker_i (.i_ref_clk,
  .i_nrst, .i_csr_rd_en, .i_csr_wr_en, .i_csr_addr, .i_csr_wdata, .i_ext_irq, .o_csr_rdata,
  .o_csr_hit, .o_dma_qos, .o_dual_issue_off, .o_se_load_blocking, .o_cg_override,
  .o_ext_irq_req);

//--- core_low_level_ctrl_csrs_test.sv
/*
  Self-checking bench of the core low-level control register bank.
  Assumes the bank answers reads one cycle after the request.
*/
module core_low_level_ctrl_csrs_test
  import cllc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUS_AXI = 1;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_csr_rd_en = 1'b0, i_csr_wr_en = 1'b0;
  logic i_ce_irq = 1'b0, i_ext_irq = 1'b0, i_tmr_irq = 1'b0, o_csr_hit, o_dual_issue_off;
  logic o_ecc_chk_off, o_alu2_off, o_se_store_blocking, o_se_load_blocking, o_nonblock_off;
  logic o_fast_div_off, o_bpred_off, o_coalesce_off, o_pipelining_off, hitv;
  logic o_ce_irq_req, o_ext_irq_req, o_tmr_irq_req;
  logic [11:0] i_csr_addr = 12'h0;
  logic [31:0] i_csr_wdata = 32'h0, o_csr_rdata, rdv, d, v, fdc_seen, seed = 32'h20e6ff38;
  logic [2:0]  o_dma_qos;
  logic [8:0]  o_cg_override;
  logic [31:0] exp_r [4];
  logic [11:0] ad [4] = '{12'h304, 12'h344, 12'h7f8, 12'h7f9};
  logic [31:0] mk [4] = '{32'h40000888, 32'h0, 32'h000001ff, 32'h000705fd};
  int failures = 0, total_checks = 0, k;
  always #4 i_ref_clk = ~i_ref_clk;
  assign fdc_seen = {13'h0, o_dma_qos, 5'h0, o_dual_issue_off, 1'b0, o_ecc_chk_off, o_alu2_off,
    o_se_store_blocking, o_nonblock_off, o_fast_div_off, o_bpred_off, o_coalesce_off, 1'b0,
    o_pipelining_off};
  cllc_csrs #(.BUS_AXI(BUS_AXI)) cllc_csrs_i (.i_ref_clk, .i_nrst, .i_csr_rd_en, .i_csr_wr_en,
    .i_csr_addr, .i_csr_wdata, .i_ce_irq, .i_ext_irq, .i_tmr_irq, .o_csr_rdata, .o_csr_hit,
    .o_dma_qos, .o_dual_issue_off, .o_ecc_chk_off, .o_alu2_off, .o_se_store_blocking,
    .o_se_load_blocking, .o_nonblock_off, .o_fast_div_off, .o_bpred_off, .o_coalesce_off,
    .o_pipelining_off, .o_cg_override, .o_ce_irq_req, .o_ext_irq_req, .o_tmr_irq_req);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] pend_exp();
    return {1'b0, i_ce_irq, 18'h0, i_ext_irq, 3'h0, i_tmr_irq, 7'h0};
  endfunction : pend_exp
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic rdr(input logic [11:0] a);
    @(posedge i_ref_clk);
    i_csr_rd_en <= 1'b1;
    i_csr_addr  <= a;
    @(posedge i_ref_clk);
    i_csr_rd_en <= 1'b0;
    #1 rdv = o_csr_rdata;
    hitv = o_csr_hit;
  endtask : rdr
  // software keeps the fences around writes; one write per call
  task automatic wrr(input logic [11:0] a, input logic [31:0] dd);
    @(posedge i_ref_clk);
    i_csr_wr_en <= 1'b1;
    i_csr_addr  <= a;
    i_csr_wdata <= dd;
    @(posedge i_ref_clk);
    i_csr_wr_en <= 1'b0;
  endtask : wrr
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #50us;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    exp_r = '{32'h0, 32'h0, 32'h0, 32'h00070000 | (BUS_AXI << 6)};
    for (int j = 0; j < 4; j++) begin
      rdr(ad[j]);
      check("reset value", rdv, exp_r[j]);
    end
    // first four passes write all ones to each register
    for (int n = 0; n < 48; n++) begin
      k = (n < 4) ? n : int'(rnd() % 4);
      d = (n < 4) ? 32'hffffffff : rnd();
      v = rnd();
      @(posedge i_ref_clk);
      {i_ce_irq, i_ext_irq, i_tmr_irq} <= v[2:0];
      wrr(ad[k], d);
      if (k != 1) exp_r[k] = d & mk[k];
      #1 check("feature outputs", fdc_seen, exp_r[3]);
      check("gate override", {23'h0, o_cg_override}, exp_r[2]);
      repeat (3) @(posedge i_ref_clk);
      #1 check("irq requests", {29'h0, o_ce_irq_req, o_ext_irq_req, o_tmr_irq_req},
        {29'h0, i_ce_irq & exp_r[0][30], i_ext_irq & exp_r[0][11], i_tmr_irq & exp_r[0][7]});
      rdr(ad[1]);
      check("pending", rdv, pend_exp());
      rdr(ad[k]);
      check("readback", rdv, (k == 1) ? pend_exp() : exp_r[k]);
      check("hit", {31'h0, hitv}, 32'h1);
    end
    rdr(12'h7fa);
    check("unmapped data", rdv, 32'h0);
    check("unmapped hit", {31'h0, hitv}, 32'h0);
    check("load blocking", {31'h0, o_se_load_blocking}, 32'h1);
    // second reset in mid-run must bring the enable, gate override and feature disable registers back to their reset values
    @(posedge i_ref_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 check("reset outputs", fdc_seen, 32'h00070000 | (BUS_AXI << 6));
    check("reset gate override", {23'h0, o_cg_override}, 32'h0);
    check("reset irq requests", {29'h0, o_ce_irq_req, o_ext_irq_req, o_tmr_irq_req},
      32'h0);
    @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    exp_r = '{32'h0, 32'h0, 32'h0, 32'h00070000 | (BUS_AXI << 6)};
    for (int j = 0; j < 4; j += 2) begin
      rdr(ad[j]);
      check("reset again", rdv, exp_r[j]);
    end
    rdr(ad[3]);
    check("reset again", rdv, exp_r[3]);
    report_and_stop();
  end
endmodule : core_low_level_ctrl_csrs_test
